// [verilog/dtde_pkg.sv]
// Shared constants and types for the data transfer decode/execute unit.
// Assumes one 40 MHz clock and a 16-bit byte-addressed memory bus.
package dtde_pkg;

    // Instruction repertoire and functional groups
    localparam int unsigned NUM_OPS    = 55;
    localparam logic [5:0]  OP_LAST    = 6'h36;
    // First operation index of each group, in group order
    localparam logic [5:0]  GRP_ARITH  = 6'h01;
    localparam logic [5:0]  GRP_LOGIC  = 6'h0F;
    localparam logic [5:0]  GRP_SHIFT  = 6'h13;
    localparam logic [5:0]  GRP_BIT    = 6'h1B;
    localparam logic [5:0]  GRP_BRANCH = 6'h29;
    localparam logic [5:0]  GRP_SYSCTL = 6'h2E;
    localparam logic [5:0]  GRP_BLOCK  = 6'h36;

    // Address forming
    localparam logic [7:0]  SHORT_ABS_PAGE = 8'hFF;
    localparam logic [15:0] STEP_BYTE      = 16'h0001;
    localparam logic [15:0] STEP_WORD      = 16'h0002;
    localparam logic [15:0] WORD_ALIGN     = 16'hFFFE;
    localparam logic [2:0]  STACK_REG      = 3'h7;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    typedef enum logic [2:0] {
        DTDE_GRP_TRANSFER = 3'b000,
        DTDE_GRP_ARITH    = 3'b001,
        DTDE_GRP_LOGIC    = 3'b010,
        DTDE_GRP_SHIFT    = 3'b011,
        DTDE_GRP_BIT      = 3'b100,
        DTDE_GRP_BRANCH   = 3'b101,
        DTDE_GRP_SYSCTL   = 3'b110,
        DTDE_GRP_BLOCK    = 3'b111
    } dtde_group_t;

    typedef enum logic [2:0] {
        REG_DIRECT_MODE            = 3'b000,
        REG_INDIRECT_MODE          = 3'b001,
        DISPLACEMENT_INDIRECT_MODE = 3'b010,
        LONG_ABSOLUTE_MODE         = 3'b011,
        SHORT_ABSOLUTE_MODE        = 3'b100,
        WIDE_IMMEDIATE_MODE        = 3'b101,
        PREDECREMENT_MODE          = 3'b110,
        POSTINCREMENT_MODE         = 3'b111
    } dtde_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACCESS = 2'b01,
        ST_FINISH = 2'b10
    } dtde_state_t;

    // Decoded instruction handed in by the fetch stage
    typedef struct packed {
        logic        valid;
        logic [5:0]  op_index; // 0 .. 54, 0 is the move operation
        logic        word;     // 1: move_word_op, 0: move_byte_op
        logic        store;    // 1: register to memory, 0: to register
        dtde_mode_t  mode;
        logic [2:0]  ptr_reg;  // Pointer, or for register direct the source of loads and destination of stores
        logic [2:0]  data_reg; // Source for stores, destination for loads
        logic [15:0] ext;      // Displacement, absolute or immediate
    } dtde_req_t;

    // Memory bus request
    typedef struct packed {
        logic        req;
        logic        we;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dtde_mem_t;

endpackage

// [verilog/dtde_move_unit.sv]
// Decode and execute unit for the data transfer group (move, push, pop).
// Assumes a memory bus that answers each request with a one-cycle ack.

module dtde_move_unit #(
    parameter int unsigned NREGS = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Decoded instruction
    input  wire dtde_pkg::dtde_req_t req,
    output logic                   req_ready_q,
    // Completion
    output logic                   done_q,
    output logic                   fault_q,
    output dtde_pkg::dtde_group_t  group_q,
    output logic                   stack_op_q,
    // Memory bus
    output dtde_pkg::dtde_mem_t    mem_q,
    input  wire logic              mem_ack,
    input  wire logic [15:0]       mem_rdata,
    // Register observation
    input  wire logic [2:0]        peek_sel,
    output logic [15:0]            peek_data_q
);

    // Reset release through two flip-flops
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Group of an operation index
    function automatic dtde_pkg::dtde_group_t group_of(input logic [5:0] idx);
        if (idx >= dtde_pkg::GRP_BLOCK) begin
            group_of = dtde_pkg::DTDE_GRP_BLOCK;
        end else if (idx >= dtde_pkg::GRP_SYSCTL) begin
            group_of = dtde_pkg::DTDE_GRP_SYSCTL;
        end else if (idx >= dtde_pkg::GRP_BRANCH) begin
            group_of = dtde_pkg::DTDE_GRP_BRANCH;
        end else if (idx >= dtde_pkg::GRP_BIT) begin
            group_of = dtde_pkg::DTDE_GRP_BIT;
        end else if (idx >= dtde_pkg::GRP_SHIFT) begin
            group_of = dtde_pkg::DTDE_GRP_SHIFT;
        end else if (idx >= dtde_pkg::GRP_LOGIC) begin
            group_of = dtde_pkg::DTDE_GRP_LOGIC;
        end else if (idx >= dtde_pkg::GRP_ARITH) begin
            group_of = dtde_pkg::DTDE_GRP_ARITH;
        end else begin
            group_of = dtde_pkg::DTDE_GRP_TRANSFER;
        end
    endfunction

    // State
    dtde_pkg::dtde_state_t state_q, state_d;
    logic [15:0]           regs_q [NREGS];
    logic [15:0]           regs_d [NREGS];
    logic                  ld_q, ld_d;           // Pending memory load
    logic                  post_q, post_d;       // Pending pointer increment
    logic                  wd_q, wd_d;           // Pending access is a word
    logic [2:0]            dst_q, dst_d;
    logic [2:0]            ptr_q, ptr_d;
    logic                  ready_d, done_d, fault_d, stack_d;
    dtde_pkg::dtde_group_t group_d;
    dtde_pkg::dtde_mem_t   mem_d;
    logic [15:0]           peek_d;

    // Decode, address forming and execution
    always_comb begin
        logic [15:0] step;
        logic [15:0] ptr_val;
        logic [15:0] src_val;
        logic [15:0] ea;
        logic        is_mem;
        step    = 16'h0000;
        ptr_val = 16'h0000;
        src_val = 16'h0000;
        ea      = 16'h0000;
        is_mem  = 1'b0;
        state_d = state_q;
        regs_d  = regs_q;
        ld_d    = ld_q;
        post_d  = post_q;
        wd_d    = wd_q;
        dst_d   = dst_q;
        ptr_d   = ptr_q;
        ready_d = 1'b0;
        done_d  = 1'b0;
        fault_d = 1'b0;
        stack_d = stack_op_q;
        group_d = group_q;
        mem_d   = mem_q;
        peek_d  = regs_q[peek_sel];
        case (state_q)
            dtde_pkg::ST_IDLE: begin
                ready_d = 1'b1;
                if (req.valid) begin
                    ready_d = 1'b0;
                    state_d = dtde_pkg::ST_FINISH;
                    group_d = group_of(req.op_index);
                    // Step size by operand size; register seven is trusted to be word sized
                    step    = req.word ? dtde_pkg::STEP_WORD : dtde_pkg::STEP_BYTE;
                    ptr_val = regs_q[req.ptr_reg];
                    src_val = regs_q[req.data_reg];
                    // Push and pop are word moves through register seven
                    stack_d = req.word && (req.ptr_reg == dtde_pkg::STACK_REG)
                              && (req.store ? req.mode == dtde_pkg::PREDECREMENT_MODE
                                            : req.mode == dtde_pkg::POSTINCREMENT_MODE);
                    case (req.mode)
                        dtde_pkg::REG_INDIRECT_MODE: begin
                            ea     = ptr_val;
                            is_mem = 1'b1;
                        end
                        dtde_pkg::DISPLACEMENT_INDIRECT_MODE: begin
                            ea     = ptr_val + req.ext;
                            is_mem = 1'b1;
                        end
                        dtde_pkg::LONG_ABSOLUTE_MODE: begin
                            ea     = req.ext;
                            is_mem = 1'b1;
                        end
                        dtde_pkg::SHORT_ABSOLUTE_MODE: begin
                            ea     = {dtde_pkg::SHORT_ABS_PAGE, req.ext[7:0]};
                            is_mem = 1'b1;
                        end
                        dtde_pkg::PREDECREMENT_MODE: begin
                            ea     = ptr_val - step;
                            is_mem = 1'b1;
                            regs_d[req.ptr_reg] = ea;
                        end
                        dtde_pkg::POSTINCREMENT_MODE: begin
                            ea     = ptr_val;
                            is_mem = 1'b1;
                        end
                        default: begin
                            ea     = 16'h0000;
                            is_mem = 1'b0;
                        end
                    endcase
                    if (group_d != dtde_pkg::DTDE_GRP_TRANSFER
                        || req.op_index != 6'h00
                        || (req.word && req.mode == dtde_pkg::SHORT_ABSOLUTE_MODE)
                        || (req.store && req.mode == dtde_pkg::WIDE_IMMEDIATE_MODE)) begin
                        // Not a move this unit executes: refuse without side effects
                        fault_d = 1'b1;
                        regs_d  = regs_q;
                        stack_d = 1'b0;
                    end else if (!is_mem) begin
                        // Register direct and immediate complete without the bus
                        if (req.mode == dtde_pkg::WIDE_IMMEDIATE_MODE) begin
                            regs_d[req.data_reg] = req.word ? req.ext
                                : {regs_q[req.data_reg][15:8], req.ext[7:0]};
                        end else if (req.store) begin
                            regs_d[req.ptr_reg] = req.word ? src_val
                                : {regs_q[req.ptr_reg][15:8], src_val[7:0]};
                        end else begin
                            regs_d[req.data_reg] = req.word ? ptr_val
                                : {regs_q[req.data_reg][15:8], ptr_val[7:0]};
                        end
                    end else begin
                        // Issue the memory access
                        state_d    = dtde_pkg::ST_ACCESS;
                        mem_d.req  = 1'b1;
                        mem_d.we   = req.store;
                        mem_d.word = req.word;
                        mem_d.addr = req.word ? (ea & dtde_pkg::WORD_ALIGN) : ea;
                        mem_d.wdata = req.word ? src_val : {8'h00, src_val[7:0]};
                        ld_d   = !req.store;
                        post_d = (req.mode == dtde_pkg::POSTINCREMENT_MODE);
                        wd_d   = req.word;
                        dst_d  = req.data_reg;
                        ptr_d  = req.ptr_reg;
                    end
                end
            end
            dtde_pkg::ST_ACCESS: begin
                if (mem_ack) begin
                    mem_d.req = 1'b0;
                    state_d   = dtde_pkg::ST_FINISH;
                    if (post_q) begin
                        regs_d[ptr_q] = regs_q[ptr_q]
                            + (wd_q ? dtde_pkg::STEP_WORD : dtde_pkg::STEP_BYTE);
                    end
                    // Loaded value wins when the loaded register is also the pointer
                    if (ld_q) begin
                        regs_d[dst_q] = wd_q ? mem_rdata
                            : {regs_q[dst_q][15:8], mem_rdata[7:0]};
                    end
                end
            end
            dtde_pkg::ST_FINISH: begin
                // A refused request finishes without a completion pulse
                done_d  = !fault_q;
                ready_d = 1'b1;
                state_d = dtde_pkg::ST_IDLE;
            end
            default: begin
                state_d = dtde_pkg::ST_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q     <= dtde_pkg::ST_IDLE;
            for (int i = 0; i < NREGS; i++) begin
                regs_q[i] <= dtde_pkg::REG_RESET;
            end
            ld_q        <= 1'b0;
            post_q      <= 1'b0;
            wd_q        <= 1'b0;
            dst_q       <= 3'h0;
            ptr_q       <= 3'h0;
            req_ready_q <= 1'b0;
            done_q      <= 1'b0;
            fault_q     <= 1'b0;
            group_q     <= dtde_pkg::DTDE_GRP_TRANSFER;
            stack_op_q  <= 1'b0;
            mem_q       <= '0;
            peek_data_q <= 16'h0000;
        end else begin
            state_q     <= state_d;
            regs_q      <= regs_d;
            ld_q        <= ld_d;
            post_q      <= post_d;
            wd_q        <= wd_d;
            dst_q       <= dst_d;
            ptr_q       <= ptr_d;
            req_ready_q <= ready_d;
            done_q      <= done_d;
            fault_q     <= fault_d;
            group_q     <= group_d;
            stack_op_q  <= stack_d;
            mem_q       <= mem_d;
            peek_data_q <= peek_d;
        end
    end

endmodule

// [tb/dtde_move_unit_sva.sv]
// Checker for the data transfer decode/execute unit.
// Sees only the top ports; bound from the testbench top file.
module dtde_move_unit_sva (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  arst_n,
    // Request and completion
    input wire dtde_pkg::dtde_req_t   req,
    input wire logic                  req_ready_q,
    input wire logic                  done_q,
    input wire logic                  fault_q,
    input wire dtde_pkg::dtde_group_t group_q,
    input wire logic                  stack_op_q,
    // Memory bus
    input wire dtde_pkg::dtde_mem_t   mem_q,
    input wire logic                  mem_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic       take;
    logic       mv;
    logic       stk;
    logic [7:0] ext_q;
    // Taken requests and the push/pop form
    assign take = req.valid && req_ready_q;
    assign mv   = take && req.op_index == 6'h00;
    assign stk  = req.word && req.ptr_reg == dtde_pkg::STACK_REG
                  && ((req.store && req.mode == dtde_pkg::PREDECREMENT_MODE)
                  || (!req.store && req.mode == dtde_pkg::POSTINCREMENT_MODE));
    // Short absolute offset of the last request
    always_ff @(posedge clk) begin
        ext_q <= req.ext[7:0];
    end
    AST_NONMOVE_FAULT: assert property (take && req.op_index != 6'h00 |=> fault_q && !done_q)
        else $error("non-move op not refused");
    AST_MOVE_GROUP: assert property (mv |=> group_q == dtde_pkg::DTDE_GRP_TRANSFER)
        else $error("move not in transfer group");
    AST_SHORT_WORD: assert property (mv && req.word
        && req.mode == dtde_pkg::SHORT_ABSOLUTE_MODE |=> fault_q && !mem_q.req)
        else $error("word short absolute not refused");
    AST_SHORT_PAGE: assert property (mv && !req.word
        && req.mode == dtde_pkg::SHORT_ABSOLUTE_MODE
        |=> mem_q.req && mem_q.addr == {dtde_pkg::SHORT_ABS_PAGE, ext_q})
        else $error("short absolute page wrong");
    AST_WORD_EVEN: assert property (mem_q.req && mem_q.word |-> !mem_q.addr[0])
        else $error("odd word address on bus");
    AST_IMM_STORE: assert property (mv && req.store
        && req.mode == dtde_pkg::WIDE_IMMEDIATE_MODE |=> fault_q)
        else $error("store to immediate not refused");
    AST_REG_DIRECT: assert property (mv && req.mode == dtde_pkg::REG_DIRECT_MODE
        |=> !mem_q.req && !req_ready_q ##1 done_q)
        else $error("register move timing wrong");
    AST_STACK_FORM: assert property (mv && stk
        |=> stack_op_q && mem_q.req && mem_q.word)
        else $error("push or pop form not recognised");
    AST_BUS_HOLD: assert property (mem_q.req && !mem_ack |=> $stable(mem_q))
        else $error("bus request changed before ack");
    AST_ACK_DONE: assert property (mem_q.req && mem_ack |=> !mem_q.req ##[0:1] done_q)
        else $error("no completion after ack");
    AST_DONE_PULSE: assert property (done_q |=> !done_q)
        else $error("done longer than one cycle");
    AST_FAULT_NO_DONE: assert property (fault_q |=> !done_q)
        else $error("completion pulse after refusal");
    // Main scenarios
    COV_STACK: cover property (mv && stk ##1 stack_op_q);
    COV_SLOW: cover property (mem_q.req && !mem_ack ##1 mem_q.req && !mem_ack);
    COV_FAULT: cover property (take ##1 fault_q);
endmodule

// [tb/dtde_mem_model.sv]
// Behavioural memory on the far side of the unit's bus.
// Big-endian words; answers after wait_n idle cycles with a one-cycle ack.
module dtde_mem_model (
    // Clock and reset
    input wire logic                clk,
    input wire logic                arst_n,
    // Bus from the unit
    input wire dtde_pkg::dtde_mem_t mem_q,
    input wire logic [1:0]          wait_n,
    output logic                    mem_ack,
    output logic [15:0]             mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  mem [0:65535];
    logic [1:0]  cnt;
    logic [15:0] a1;
    assign a1 = mem_q.addr | 16'h0001;
    // Answer, store and load; read data scrambles outside the ack cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_ack <= 1'b0;
            cnt <= 2'h0;
            mem_rdata <= 16'h0000;
        end else if (mem_q.req && !mem_ack && cnt >= wait_n) begin
            mem_ack <= 1'b1;
            cnt <= 2'h0;
            if (mem_q.we) mem[mem_q.addr] <= mem_q.word ? mem_q.wdata[15:8] : mem_q.wdata[7:0];
            if (mem_q.we && mem_q.word) mem[a1] <= mem_q.wdata[7:0];
            mem_rdata <= mem_q.word ? {mem[mem_q.addr], mem[a1]}
                                    : {~mem[mem_q.addr], mem[mem_q.addr]};
        end else begin
            mem_ack <= 1'b0;
            cnt <= (mem_q.req && !mem_ack) ? cnt + 2'h1 : 2'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// [tb/dtde_move_unit_test.sv]
// Self-checking testbench for the data transfer decode/execute unit.
// Drives inputs at the falling edge; memory is the behavioural model.
module dtde_move_unit_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic                  clk;
    logic                  arst_n;
    dtde_pkg::dtde_req_t   req;
    logic                  req_ready_q;
    logic                  done_q;
    logic                  fault_q;
    dtde_pkg::dtde_group_t group_q;
    logic                  stack_op_q;
    dtde_pkg::dtde_mem_t   mem_q;
    logic                  mem_ack;
    logic [15:0]           mem_rdata;
    logic [2:0]            peek_sel;
    logic [15:0]           peek_data_q;
    logic [1:0]            wait_n;
    int                    n_errors;
    int                    num_checks;

    dtde_move_unit i_dut (.clk(clk), .arst_n(arst_n), .req(req), .req_ready_q(req_ready_q),
        .done_q(done_q), .fault_q(fault_q), .group_q(group_q), .stack_op_q(stack_op_q),
        .mem_q(mem_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .peek_sel(peek_sel),
        .peek_data_q(peek_data_q));
    dtde_mem_model i_mem (.clk(clk), .arst_n(arst_n), .mem_q(mem_q), .wait_n(wait_n),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One request, then its completion or refusal
    task automatic issue(input logic [5:0] op, input logic w, input logic st,
        input dtde_pkg::dtde_mode_t md, input logic [2:0] p, input logic [2:0] d,
        input logic [15:0] x, input logic flt);
        int i;
        for (i = 0; i < 40 && req_ready_q !== 1'b1; i++) @(negedge clk);
        req = '{1'b1, op, w, st, md, p, d, x};
        @(negedge clk);
        req.valid = 1'b0;
        for (i = 0; i < 40 && done_q !== 1'b1 && fault_q !== 1'b1; i++) @(negedge clk);
        chk({14'h0, fault_q, done_q}, {14'h0, flt, !flt});
        // A refusal must not be followed by a completion
        if (flt) begin
            @(negedge clk);
            chk({15'h0, done_q}, 16'h0000);
        end
    endtask

    task automatic set_reg(input logic [2:0] r, input logic [15:0] v);
        issue(6'h00, 1'b1, 1'b0, dtde_pkg::WIDE_IMMEDIATE_MODE, 3'h0, r, v, 1'b0);
    endtask

    task automatic peek(input logic [2:0] r, input logic [15:0] exp);
        peek_sel = r;
        @(negedge clk);
        chk(peek_data_q, exp);
    endtask

    task automatic t_reg_moves();
        set_reg(3'h1, 16'hA5C3);
        issue(6'h00, 1'b1, 1'b1, dtde_pkg::REG_DIRECT_MODE, 3'h2, 3'h1, 16'h0, 1'b0);
        peek(3'h2, 16'hA5C3);
        chk({13'h0, group_q}, 16'h0000);
        issue(6'h00, 1'b0, 1'b0, dtde_pkg::REG_DIRECT_MODE, 3'h2, 3'h5, 16'h0, 1'b0);
        peek(3'h5, 16'h00C3);
        issue(6'h00, 1'b0, 1'b0, dtde_pkg::WIDE_IMMEDIATE_MODE, 3'h0, 3'h1, 16'h77, 1'b0);
        peek(3'h1, 16'hA577);
        issue(6'h00, 1'b1, 1'b1, dtde_pkg::WIDE_IMMEDIATE_MODE, 3'h0, 3'h1, 16'h0, 1'b1);
    endtask

    // Push then a slow pop through register seven; word size only
    task automatic t_stack();
        set_reg(3'h7, 16'h0100);
        set_reg(3'h3, 16'h1234);
        issue(6'h00, 1'b1, 1'b1, dtde_pkg::PREDECREMENT_MODE, 3'h7, 3'h3, 16'h0, 1'b0);
        chk({15'h0, stack_op_q}, 16'h0001);
        peek(3'h7, 16'h00FE);
        chk({i_mem.mem[16'h00FE], i_mem.mem[16'h00FF]}, 16'h1234);
        wait_n = 2'h3;
        issue(6'h00, 1'b1, 1'b0, dtde_pkg::POSTINCREMENT_MODE, 3'h7, 3'h4, 16'h0, 1'b0);
        wait_n = 2'h0;
        peek(3'h4, 16'h1234);
        peek(3'h7, 16'h0100);
    endtask

    task automatic t_byte_steps();
        set_reg(3'h5, 16'h2000);
        issue(6'h00, 1'b0, 1'b1, dtde_pkg::PREDECREMENT_MODE, 3'h5, 3'h3, 16'h0, 1'b0);
        peek(3'h5, 16'h1FFF);
        chk({15'h0, stack_op_q}, 16'h0000);
        chk({8'h00, i_mem.mem[16'h1FFF]}, 16'h0034);
        issue(6'h00, 1'b0, 1'b0, dtde_pkg::POSTINCREMENT_MODE, 3'h5, 3'h6, 16'h0, 1'b0);
        peek(3'h6, 16'h0034);
        peek(3'h5, 16'h2000);
    endtask

    task automatic t_addr_modes();
        i_mem.mem[16'hFF10] = 8'h5A;
        i_mem.mem[16'h0300] = 8'hBE;
        i_mem.mem[16'h0301] = 8'hEF;
        i_mem.mem[16'h2010] = 8'hCA;
        i_mem.mem[16'h2011] = 8'hFE;
        issue(6'h00, 1'b0, 1'b0, dtde_pkg::SHORT_ABSOLUTE_MODE, 3'h0, 3'h2, 16'h10, 1'b0);
        peek(3'h2, 16'hA55A);
        issue(6'h00, 1'b1, 1'b0, dtde_pkg::SHORT_ABSOLUTE_MODE, 3'h0, 3'h2, 16'h10, 1'b1);
        peek(3'h2, 16'hA55A);
        issue(6'h00, 1'b1, 1'b0, dtde_pkg::LONG_ABSOLUTE_MODE, 3'h0, 3'h0, 16'h301, 1'b0);
        peek(3'h0, 16'hBEEF);
        issue(6'h00, 1'b1, 1'b0, dtde_pkg::DISPLACEMENT_INDIRECT_MODE, 3'h5, 3'h1, 16'h10, 1'b0);
        peek(3'h1, 16'hCAFE);
        issue(6'h00, 1'b0, 1'b1, dtde_pkg::REG_INDIRECT_MODE, 3'h5, 3'h0, 16'h0, 1'b0);
        chk({8'h00, i_mem.mem[16'h2000]}, 16'h00EF);
    endtask

    // Every non-move index is refused and reports its group
    task automatic t_groups();
        logic [2:0] g;
        for (int k = 1; k < 64; k++) begin
            g = k > 53 ? 3'h7 : k > 45 ? 3'h6 : k > 40 ? 3'h5 : k > 26 ? 3'h4
                : k > 18 ? 3'h3 : k > 14 ? 3'h2 : 3'h1;
            issue(6'(k), 1'b0, 1'b0, dtde_pkg::REG_DIRECT_MODE, 3'h0, 3'h0, 16'h0, 1'b1);
            chk({13'h0, group_q}, {13'h0, g});
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        req = '0;
        peek_sel = 3'h0;
        wait_n = 2'h0;
        n_errors = 0;
        num_checks = 0;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        t_reg_moves();
        t_stack();
        t_byte_steps();
        t_addr_modes();
        t_groups();
        test_done();
    end

    // Watchdog well beyond the expected run
    initial begin
        #250000;
        n_errors++;
        test_done();
    end
endmodule

bind dtde_move_unit dtde_move_unit_sva i_sva (.clk(clk), .arst_n(arst_n), .req(req),
    .req_ready_q(req_ready_q), .done_q(done_q), .fault_q(fault_q), .group_q(group_q),
    .stack_op_q(stack_op_q), .mem_q(mem_q), .mem_ack(mem_ack));
